// file: sysref_cfg_pkg.sv
package sysref_cfg_pkg;

	// serial frame layout: one direction bit, a byte address, then data bytes
	localparam int ADDR_W = 15;
	localparam int DATA_W = 8;
	localparam int HDR_BITS = 16;
	localparam logic [4:0] HDR_LAST = 5'h0f;
	localparam logic [2:0] BYTE_LAST = 3'h7;

	// byte addresses of the register group
	localparam logic [ADDR_W-1:0] ADDR_CAPTURE_CTRL = 15'h0029;
	localparam logic [ADDR_W-1:0] ADDR_CLK_FORMAT = 15'h002a;
	localparam logic [ADDR_W-1:0] ADDR_EDGE_POS_HI = 15'h002c;
	localparam logic [ADDR_W-1:0] ADDR_EDGE_POS_MID = 15'h002d;
	localparam logic [ADDR_W-1:0] ADDR_EDGE_POS_LO = 15'h002e;
	localparam logic [ADDR_W-1:0] ADDR_FS_A_HI = 15'h0030;
	localparam logic [ADDR_W-1:0] ADDR_FS_A_LO = 15'h0031;
	localparam logic [ADDR_W-1:0] ADDR_FS_B_HI = 15'h0032;
	localparam logic [ADDR_W-1:0] ADDR_FS_B_LO = 15'h0033;
	localparam logic [ADDR_W-1:0] ADDR_REF_BYPASS = 15'h0038;
	localparam logic [ADDR_W-1:0] ADDR_TIMESTAMP = 15'h003b;

	// values after reset
	localparam logic [7:0] RST_CAPTURE_CTRL = 8'h00;
	localparam logic [7:0] RST_CLK_FORMAT = 8'h20;
	localparam logic [15:0] RST_FULLSCALE = 16'ha000;
	localparam logic [7:0] RST_REF_BYPASS = 8'h00;
	localparam logic [7:0] RST_TIMESTAMP = 8'h00;
	localparam logic [23:0] RST_EDGE_POS = 24'h000000;
	localparam logic [7:0] RD_UNMAPPED = 8'h00;

	// field positions, sysref capture control
	localparam int CAP_PROC_EN_BIT = 6;
	localparam int CAP_RECV_ON_BIT = 5;
	localparam int CAP_FINE_WIN_BIT = 4;
	localparam int CAP_DELAY_MSB = 3;
	localparam int CAP_DELAY_LSB = 0;
	localparam logic [3:0] DELAY_AUTO = 4'h0;

	// field positions, clock input format
	localparam int FMT_DEVICE_CLOCK_IN_PECL_BIT = 2;
	localparam int FMT_SYSREF_PECL_BIT = 1;
	localparam int FMT_POL_FLIP_BIT = 0;

	// field positions, reference bypass and timestamp control
	localparam int REF_BYPASS_BIT = 0;
	localparam int TS_PECL_BIT = 1;
	localparam int TS_ON_BIT = 0;

	// synchroniser depth for pin inputs
	localparam int SYNC_STAGES = 3;

endpackage

// file: cfg_access_if.sv
`timescale 1ns/1ps
// byte access from the serial port engine into the register group
interface cfg_access_if;
	import sysref_cfg_pkg::*;
	logic wr_stb;
	logic rd_stb;
	logic [ADDR_W-1:0] addr;
	logic [DATA_W-1:0] wdata;
	logic [DATA_W-1:0] rdata;

	modport port (output wr_stb, output rd_stb, output addr, output wdata,
		input rdata);
	modport regs (input wr_stb, input rd_stb, input addr, input wdata,
		output rdata);
endinterface

// file: cfg_serial_port.sv
`timescale 1ns/1ps
module cfg_serial_port
	import sysref_cfg_pkg::*;
(
	input wire logic sys_clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic sclk_i, // serial clock pin
	input wire logic csb_n_i, // chip select pin, low active
	input wire logic sdi_i, // serial data in pin
	output logic sdo_o, // serial data out
	output logic sdo_oe_n_o, // serial out enable, low while driving
	cfg_access_if.port bus // byte access to registers
);

	logic [SYNC_STAGES-1:0] sclk_s_r;
	logic [SYNC_STAGES-1:0] csb_s_r;
	logic [SYNC_STAGES-1:0] sdi_s_r;
	logic sclk_q_r;
	logic csb_q_r;
	logic sdi_q_r;
	logic sclk_rise;
	logic sclk_fall;
	logic sel;
	logic hdr_done_r;
	logic is_read_r;
	logic [4:0] hdr_cnt_r;
	logic [14:0] hdr_sh_r;
	logic [2:0] data_cnt_r;
	logic [6:0] rx_sh_r;
	logic [7:0] tx_r;
	logic wr_stb_r;
	logic rd_stb_r;
	logic [ADDR_W-1:0] addr_r;
	logic [7:0] wdata_r;
	logic [15:0] hdr_word;

	// three-stage pin synchronisers; stage one feeds only stage two
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sclk_s_r <= '0;
			csb_s_r <= '1;
			sdi_s_r <= '0;
		end else begin
			sclk_s_r <= {sclk_s_r[1:0], sclk_i};
			csb_s_r <= {csb_s_r[1:0], csb_n_i};
			sdi_s_r <= {sdi_s_r[1:0], sdi_i};
		end
	end

	// a pin level counts once stages two and three agree
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sclk_q_r <= 1'b0;
			csb_q_r <= 1'b1;
			sdi_q_r <= 1'b0;
		end else begin
			if (sclk_s_r[1] == sclk_s_r[2])
				sclk_q_r <= sclk_s_r[2];
			if (csb_s_r[1] == csb_s_r[2])
				csb_q_r <= csb_s_r[2];
			if (sdi_s_r[1] == sdi_s_r[2])
				sdi_q_r <= sdi_s_r[2];
		end
	end

	assign sel = !csb_q_r;
	assign sclk_rise = sel && (sclk_s_r[1] == sclk_s_r[2]) &&
		sclk_s_r[2] && !sclk_q_r;
	assign sclk_fall = sel && (sclk_s_r[1] == sclk_s_r[2]) &&
		!sclk_s_r[2] && sclk_q_r;
	assign hdr_word = {hdr_sh_r, sdi_q_r};

	// header and data bit counting; deselect restarts the frame
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || !sel) begin
			hdr_done_r <= 1'b0;
			is_read_r <= 1'b0;
			hdr_cnt_r <= 5'h00;
			hdr_sh_r <= '0;
			data_cnt_r <= 3'h0;
			rx_sh_r <= '0;
		end else if (sclk_rise) begin
			if (!hdr_done_r) begin
				hdr_sh_r <= hdr_word[14:0];
				hdr_cnt_r <= hdr_cnt_r + 5'h01;
				if (hdr_cnt_r == HDR_LAST) begin
					hdr_done_r <= 1'b1;
					is_read_r <= hdr_word[15];
				end
			end else begin
				rx_sh_r <= {rx_sh_r[5:0], sdi_q_r};
				data_cnt_r <= data_cnt_r + 3'h1;
			end
		end
	end

	// streaming address: taken from the header, then one up per byte
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			addr_r <= '0;
		end else if (sclk_rise && !hdr_done_r && hdr_cnt_r == HDR_LAST) begin
			addr_r <= hdr_word[14:0];
		end else if (wr_stb_r) begin
			addr_r <= addr_r + 15'h0001;
		end else if (sclk_rise && hdr_done_r && is_read_r &&
			data_cnt_r == BYTE_LAST) begin
			addr_r <= addr_r + 15'h0001;
		end
	end

	// strobes into the register group, one cycle each
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			wr_stb_r <= 1'b0;
			rd_stb_r <= 1'b0;
			wdata_r <= '0;
		end else begin
			wr_stb_r <= sclk_rise && hdr_done_r && !is_read_r &&
				data_cnt_r == BYTE_LAST;
			// the direction flag lands on the last header rise, so that
			// first strobe must look at the incoming header bit itself
			rd_stb_r <= sclk_rise &&
				((!hdr_done_r && hdr_cnt_r == HDR_LAST && hdr_word[15]) ||
				(hdr_done_r && is_read_r && data_cnt_r == BYTE_LAST));
			if (sclk_rise && hdr_done_r && data_cnt_r == BYTE_LAST)
				wdata_r <= {rx_sh_r, sdi_q_r};
		end
	end

	// read shifter: first bit shown on load, next bits after falling edges
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			tx_r <= '0;
		end else if (rd_stb_r) begin
			tx_r <= bus.rdata;
		end else if (sclk_fall && hdr_done_r && is_read_r &&
			data_cnt_r != 3'h0) begin
			tx_r <= {tx_r[6:0], 1'b0};
		end
	end

	// drive the data pin only in the data phase of a read frame
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			sdo_oe_n_o <= 1'b1;
		else
			sdo_oe_n_o <= !(sel && hdr_done_r && is_read_r);
	end

	assign sdo_o = tx_r[7];
	assign bus.wr_stb = wr_stb_r;
	assign bus.rd_stb = rd_stb_r;
	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;

endmodule

// file: sysref_clock_input_config_regs.sv
`timescale 1ns/1ps
module sysref_clock_input_config_regs
	import sysref_cfg_pkg::*;
#(
	parameter int DELAY_TAPS = 16 // delay line length, one per choice code
)
(
	input wire logic sys_clk_i, // system clock, 100 MHz
	input wire logic rst_i, // synchronous reset, high
	input wire logic sclk_i, // serial clock pin
	input wire logic csb_n_i, // serial chip select, low active
	input wire logic sdi_i, // serial data in
	output logic sdo_o, // serial data out
	output logic sdo_oe_n_o, // serial out enable, low while driving
	input wire logic sysref_i, // sysref pin after the receiver
	input wire logic [3:0] cal_delay_i, // delay found by calibration
	input wire logic [23:0] edge_coarse_i, // edge status, normal window
	input wire logic [23:0] edge_fine_i, // edge status, zoomed window
	output logic sysref_event_o, // one-cycle sysref event, delayed by the chosen tap plus one cycle
	output logic sysref_receiver_on_o, // sysref receiver power
	output logic sysref_processor_enable_o, // sysref processor on
	output logic sysref_fine_window_o, // zoomed strobe status
	output logic [3:0] sysref_delay_choice_o, // delay choice field
	output logic sysref_auto_cal_o, // automatic delay calibration on
	output logic sysref_polarity_flip_o, // sysref_polarity_flip
	output logic devclock_lowv_pecl_o, // device clock input pecl mode
	output logic sysref_lowv_pecl_o, // sysref input pecl mode
	output logic [15:0] input_a_fullscale_code_o, // input a range code
	output logic [15:0] input_b_fullscale_code_o, // input b range code
	output logic reference_bypass_o, // core supply rail as reference
	output logic timestamp_input_on_o, // timestamp input enable
	output logic timestamp_lowv_pecl_o // timestamp input pecl mode
);

	cfg_access_if acc ();

	logic [7:0] capture_ctrl_r;
	logic [7:0] clk_format_r;
	logic [15:0] fs_a_r;
	logic [15:0] fs_b_r;
	logic [7:0] ref_bypass_r;
	logic [7:0] timestamp_r;
	logic [23:0] edge_pos_r;
	logic [7:0] rdata_nxt;
	logic [SYNC_STAGES-1:0] sysref_s_r;
	logic sysref_q_r;
	logic aligned_r;
	logic aligned;
	logic ev_now;
	logic [DELAY_TAPS-2:0] delay_r;
	logic [DELAY_TAPS-1:0] taps;
	logic [3:0] tap_sel;

	// serial port engine; frames reach registers as byte strobes
	cfg_serial_port u_port (
		.sys_clk_i(sys_clk_i),
		.rst_i(rst_i),
		.sclk_i(sclk_i),
		.csb_n_i(csb_n_i),
		.sdi_i(sdi_i),
		.sdo_o(sdo_o),
		.sdo_oe_n_o(sdo_oe_n_o),
		.bus(acc.port)
	);

	// sysref capture control, reserved bit 7 kept as written
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			capture_ctrl_r <= RST_CAPTURE_CTRL;
		else if (acc.wr_stb && acc.addr == ADDR_CAPTURE_CTRL)
			capture_ctrl_r <= acc.wdata;
	end

	// clock input format; reserved bits store whatever software writes
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			clk_format_r <= RST_CLK_FORMAT;
		else if (acc.wr_stb && acc.addr == ADDR_CLK_FORMAT)
			clk_format_r <= acc.wdata;
	end

	// full-scale codes, high byte at the lower address
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			fs_a_r <= RST_FULLSCALE;
			fs_b_r <= RST_FULLSCALE;
		end else if (acc.wr_stb) begin
			if (acc.addr == ADDR_FS_A_HI)
				fs_a_r[15:8] <= acc.wdata;
			if (acc.addr == ADDR_FS_A_LO)
				fs_a_r[7:0] <= acc.wdata;
			if (acc.addr == ADDR_FS_B_HI)
				fs_b_r[15:8] <= acc.wdata;
			if (acc.addr == ADDR_FS_B_LO)
				fs_b_r[7:0] <= acc.wdata;
		end
	end

	// reference bypass and timestamp control bytes
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ref_bypass_r <= RST_REF_BYPASS;
			timestamp_r <= RST_TIMESTAMP;
		end else if (acc.wr_stb) begin
			if (acc.addr == ADDR_REF_BYPASS)
				ref_bypass_r <= acc.wdata;
			if (acc.addr == ADDR_TIMESTAMP)
				timestamp_r <= acc.wdata;
		end
	end

	// read mux; the three edge bytes come from one snapshot register
	always_comb begin
		rdata_nxt = RD_UNMAPPED;
		unique case (acc.addr)
			ADDR_CAPTURE_CTRL: rdata_nxt = capture_ctrl_r;
			ADDR_CLK_FORMAT: rdata_nxt = clk_format_r;
			ADDR_EDGE_POS_HI: rdata_nxt = edge_pos_r[23:16];
			ADDR_EDGE_POS_MID: rdata_nxt = edge_pos_r[15:8];
			ADDR_EDGE_POS_LO: rdata_nxt = edge_pos_r[7:0];
			ADDR_FS_A_HI: rdata_nxt = fs_a_r[15:8];
			ADDR_FS_A_LO: rdata_nxt = fs_a_r[7:0];
			ADDR_FS_B_HI: rdata_nxt = fs_b_r[15:8];
			ADDR_FS_B_LO: rdata_nxt = fs_b_r[7:0];
			ADDR_REF_BYPASS: rdata_nxt = ref_bypass_r;
			ADDR_TIMESTAMP: rdata_nxt = timestamp_r;
			default: rdata_nxt = RD_UNMAPPED;
		endcase
	end
	assign acc.rdata = rdata_nxt;

	// sysref pin synchroniser, three flops, level taken when two agree
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			sysref_s_r <= '0;
			sysref_q_r <= 1'b0;
		end else begin
			sysref_s_r <= {sysref_s_r[1:0], sysref_i};
			if (sysref_s_r[1] == sysref_s_r[2])
				sysref_q_r <= sysref_s_r[2];
		end
	end

	// polarity, then gating by the receiver; an off receiver reads low
	assign aligned = sysref_receiver_on_o &&
		(sysref_q_r ^ sysref_polarity_flip_o);

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			aligned_r <= 1'b0;
		else
			aligned_r <= aligned;
	end

	// rising edge becomes an event only with the processor enabled
	assign ev_now = aligned && !aligned_r && sysref_processor_enable_o;

	// delay line; tap zero is the undelayed event
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			delay_r <= '0;
		else
			delay_r <= {delay_r[DELAY_TAPS-3:0], ev_now};
	end
	assign taps = {delay_r, ev_now};
	// code zero hands the choice to the calibration result
	assign tap_sel = (sysref_delay_choice_o == DELAY_AUTO) ?
		cal_delay_i : sysref_delay_choice_o;

	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			sysref_event_o <= 1'b0;
		else
			sysref_event_o <= taps[tap_sel];
	end

	// edge position snapshot per processed event; zoom picks the window
	always_ff @(posedge sys_clk_i) begin
		if (rst_i)
			edge_pos_r <= RST_EDGE_POS;
		else if (ev_now)
			edge_pos_r <= sysref_fine_window_o ?
				edge_fine_i : edge_coarse_i;
	end

	// control fields straight from the registers
	assign sysref_processor_enable_o = capture_ctrl_r[CAP_PROC_EN_BIT];
	assign sysref_receiver_on_o = capture_ctrl_r[CAP_RECV_ON_BIT];
	assign sysref_fine_window_o = capture_ctrl_r[CAP_FINE_WIN_BIT];
	assign sysref_delay_choice_o =
		capture_ctrl_r[CAP_DELAY_MSB:CAP_DELAY_LSB];
	assign sysref_auto_cal_o = (sysref_delay_choice_o == DELAY_AUTO);
	assign sysref_polarity_flip_o = clk_format_r[FMT_POL_FLIP_BIT];
	assign devclock_lowv_pecl_o = clk_format_r[FMT_DEVICE_CLOCK_IN_PECL_BIT];
	assign sysref_lowv_pecl_o = clk_format_r[FMT_SYSREF_PECL_BIT];
	assign input_a_fullscale_code_o = fs_a_r;
	assign input_b_fullscale_code_o = fs_b_r;
	assign reference_bypass_o = ref_bypass_r[REF_BYPASS_BIT];
	assign timestamp_input_on_o = timestamp_r[TS_ON_BIT];
	assign timestamp_lowv_pecl_o = timestamp_r[TS_PECL_BIT];

endmodule

// file: sysref_cfg_asserts.sv
`timescale 1ns/1ps
module sysref_cfg_asserts
	import sysref_cfg_pkg::*;
#(
	parameter int DELAY_TAPS = 16 // delay line length
)
(
	input wire logic sys_clk_i, // system clock
	input wire logic rst_i, // synchronous reset
	input wire logic csb_n_i, // chip select, low active
	input wire logic sdo_oe_n_o, // serial out enable, low active
	input wire logic sysref_event_o, // delayed sysref event
	input wire logic sysref_receiver_on_o, // receiver power
	input wire logic sysref_processor_enable_o, // processor on
	input wire logic [3:0] sysref_delay_choice_o, // delay choice
	input wire logic sysref_auto_cal_o, // automatic calibration
	input wire logic sysref_polarity_flip_o, // sysref_polarity_flip
	input wire logic [15:0] input_a_fullscale_code_o, // code a
	input wire logic [15:0] input_b_fullscale_code_o, // code b
	input wire logic reference_bypass_o, // reference bypass
	input wire logic timestamp_input_on_o // timestamp enable
);
	// an event already in the delay line may still drain after disarming
	localparam int EV_MAX = DELAY_TAPS + 5;
	logic [5:0] off_cnt_r;

	// cycles since the event path was last armed, saturating
	always_ff @(posedge sys_clk_i) begin
		if (rst_i || (sysref_processor_enable_o && sysref_receiver_on_o))
			off_cnt_r <= 6'h00;
		else if (off_cnt_r != 6'h3f)
			off_cnt_r <= off_cnt_r + 6'h01;
	end

	default clocking @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	property p_evt_gate;
		sysref_event_o |-> off_cnt_r < EV_MAX;
	endproperty
	a_evt_gate: assert property (p_evt_gate)
		else $error("event while sysref path disarmed");
	property p_evt_pulse;
		sysref_event_o |=> !sysref_event_o;
	endproperty
	a_evt_pulse: assert property (p_evt_pulse)
		else $error("event longer than one cycle");
	property p_auto_cal;
		sysref_auto_cal_o == (sysref_delay_choice_o == DELAY_AUTO);
	endproperty
	a_auto_cal: assert property (p_auto_cal)
		else $error("auto calibration decode wrong");
	property p_fs_a_frame;
		$changed(input_a_fullscale_code_o) |-> !csb_n_i;
	endproperty
	a_fs_a_frame: assert property (p_fs_a_frame)
		else $error("code a changed outside a frame");
	property p_fs_b_frame;
		$changed(input_b_fullscale_code_o) |-> !csb_n_i;
	endproperty
	a_fs_b_frame: assert property (p_fs_b_frame)
		else $error("code b changed outside a frame");
	property p_oe_start;
		$fell(sdo_oe_n_o) |-> !csb_n_i;
	endproperty
	a_oe_start: assert property (p_oe_start)
		else $error("serial out driven without select");
	property p_oe_idle;
		csb_n_i [*8] |-> sdo_oe_n_o;
	endproperty
	a_oe_idle: assert property (p_oe_idle)
		else $error("serial out still driven after frame");
	property p_rst_fs;
		$fell(rst_i) |-> input_a_fullscale_code_o == RST_FULLSCALE &&
			input_b_fullscale_code_o == RST_FULLSCALE;
	endproperty
	a_rst_fs: assert property (p_rst_fs)
		else $error("full-scale codes wrong after reset");
	property p_rst_ctl;
		$fell(rst_i) |-> !(sysref_processor_enable_o || sysref_receiver_on_o ||
			reference_bypass_o || timestamp_input_on_o || sysref_polarity_flip_o);
	endproperty
	a_rst_ctl: assert property (p_rst_ctl)
		else $error("control bits set after reset");
	property p_idle_stable;
		csb_n_i [*8] |=> $stable({sysref_delay_choice_o,
			sysref_polarity_flip_o, reference_bypass_o});
	endproperty
	a_idle_stable: assert property (p_idle_stable)
		else $error("control changed with port idle");

	c_evt: cover property (sysref_event_o);
	c_read: cover property ($fell(sdo_oe_n_o));
	c_auto: cover property (sysref_auto_cal_o && sysref_processor_enable_o);
endmodule

bind sysref_clock_input_config_regs sysref_cfg_asserts #(
	.DELAY_TAPS(DELAY_TAPS)
) sysref_cfg_asserts_inst (
	.sys_clk_i(sys_clk_i), .rst_i(rst_i), .csb_n_i(csb_n_i),
	.sdo_oe_n_o(sdo_oe_n_o), .sysref_event_o(sysref_event_o),
	.sysref_receiver_on_o(sysref_receiver_on_o),
	.sysref_processor_enable_o(sysref_processor_enable_o),
	.sysref_delay_choice_o(sysref_delay_choice_o),
	.sysref_auto_cal_o(sysref_auto_cal_o),
	.sysref_polarity_flip_o(sysref_polarity_flip_o),
	.input_a_fullscale_code_o(input_a_fullscale_code_o),
	.input_b_fullscale_code_o(input_b_fullscale_code_o),
	.reference_bypass_o(reference_bypass_o),
	.timestamp_input_on_o(timestamp_input_on_o)
);

// file: tb.sv
`timescale 1ns/1ps
module tb;
	import sysref_cfg_pkg::*;
	logic sys_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic sclk_i = 1'b0, csb_n_i = 1'b1, sdi_i = 1'b0, sysref_i = 1'b0;
	logic [3:0] cal_delay_i = 4'h2;
	logic [23:0] coarse = 24'h123456, fine_pos = 24'h9abcde;
	logic sdo_o, oe_n, ev, rx_on, proc_on, fine, auto_cal, flip;
	logic dc_pecl, sr_pecl, bypass, ts_on, ts_pecl;
	logic [3:0] dly;
	logic [15:0] fs_a, fs_b;
	int n_mismatch = 0;
	int n_tests = 0;

	sysref_clock_input_config_regs sysref_clock_input_config_regs_inst (
		.sys_clk_i(sys_clk_i), .rst_i(rst_i), .sclk_i(sclk_i),
		.csb_n_i(csb_n_i), .sdi_i(sdi_i), .sdo_o(sdo_o), .sdo_oe_n_o(oe_n),
		.sysref_i(sysref_i), .cal_delay_i(cal_delay_i),
		.edge_coarse_i(coarse), .edge_fine_i(fine_pos),
		.sysref_event_o(ev), .sysref_receiver_on_o(rx_on),
		.sysref_processor_enable_o(proc_on), .sysref_fine_window_o(fine),
		.sysref_delay_choice_o(dly), .sysref_auto_cal_o(auto_cal),
		.sysref_polarity_flip_o(flip), .devclock_lowv_pecl_o(dc_pecl),
		.sysref_lowv_pecl_o(sr_pecl), .input_a_fullscale_code_o(fs_a),
		.input_b_fullscale_code_o(fs_b), .reference_bypass_o(bypass),
		.timestamp_input_on_o(ts_on), .timestamp_lowv_pecl_o(ts_pecl)
	);

	// 100 MHz system clock
	initial begin
		forever #5 sys_clk_i = ~sys_clk_i;
	end

	task automatic chk(input logic [31:0] got, exp, input string m);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(negedge sys_clk_i);
	endtask

	// serial frame, 8-cycle sclk halves keep the synchronisers well fed
	task automatic spi(input logic rd, input logic [14:0] a, input int n,
		input logic [31:0] wd, output logic [31:0] rv);
		logic [47:0] f;
		f = {rd, a, 32'(wd << (8 * (4 - n)))};
		rv = 32'h0;
		csb_n_i = 1'b0;
		tick(8);
		for (int i = 0; i < 16 + 8 * n; i++) begin
			sdi_i = f[47 - i];
			tick(8);
			if (i >= 16) rv = {rv[30:0], sdo_o};
			if (i >= 16 && rd) chk(32'(oe_n), 32'h0, "oe low");
			sclk_i = 1'b1;
			tick(8);
			sclk_i = 1'b0;
		end
		tick(8);
		csb_n_i = 1'b1;
		sdi_i = ~sdi_i;
		tick(12);
		chk(32'(oe_n), 32'h1, "oe idle");
	endtask

	task automatic wr(input logic [14:0] a, input int n, input logic [31:0] d);
		logic [31:0] r;
		spi(1'b0, a, n, d, r);
	endtask

	task automatic rd(input logic [14:0] a, input int n, input logic [31:0] e,
		input string m);
		logic [31:0] r;
		spi(1'b1, a, n, 32'h0, r);
		chk(r, e, m);
	endtask

	// pin high then low; ph names the phase that must give the event
	task automatic sr_pulse(input int ph, lo, hi, input string m);
		int k1, k2;
		k1 = 99;
		k2 = 99;
		sysref_i = 1'b1;
		for (int i = 1; i <= 30; i++) begin
			tick(1);
			if (ev === 1'b1 && k1 == 99) k1 = i;
		end
		sysref_i = 1'b0;
		for (int i = 1; i <= 30; i++) begin
			tick(1);
			if (ev === 1'b1 && k2 == 99) k2 = i;
		end
		chk(32'({(ph == 1) ? (k1 >= lo && k1 <= hi) : (k1 == 99),
			(ph == 2) ? (k2 >= lo && k2 <= hi) : (k2 == 99)}), 32'h3, m);
	endtask

	task automatic t_reset();
		chk({fs_a, fs_b}, {RST_FULLSCALE, RST_FULLSCALE}, "fs reset");
		rd(ADDR_CAPTURE_CTRL, 2, 32'({RST_CAPTURE_CTRL, RST_CLK_FORMAT}),
			"ctl reset");
		rd(ADDR_FS_A_HI, 4, 32'ha000a000, "fs reset read");
		rd(ADDR_REF_BYPASS, 1, 32'(RST_REF_BYPASS), "bypass reset");
		rd(ADDR_TIMESTAMP, 1, 32'(RST_TIMESTAMP), "ts reset");
		rd(15'h002b, 1, 32'(RD_UNMAPPED), "unmapped");
		$display("test reset done");
	endtask

	task automatic t_capture();
		wr(ADDR_CAPTURE_CTRL, 1, 32'h20);
		chk(32'({rx_on, proc_on}), 32'h2, "rx only");
		sr_pulse(0, 0, 0, "proc off");
		wr(ADDR_CAPTURE_CTRL, 1, 32'h63);
		chk(32'({proc_on, rx_on, fine, dly, auto_cal}), 32'hc6, "fields");
		sr_pulse(1, 7, 9, "tap 3");
		rd(ADDR_EDGE_POS_HI, 3, 32'(coarse), "coarse pos");
		wr(ADDR_CAPTURE_CTRL, 1, 32'h73);
		sr_pulse(1, 7, 9, "fine tap");
		rd(ADDR_EDGE_POS_HI, 3, 32'(fine_pos), "fine pos");
		wr(ADDR_EDGE_POS_HI, 1, 32'h55);
		rd(ADDR_EDGE_POS_HI, 3, 32'(fine_pos), "pos read only");
		wr(ADDR_CAPTURE_CTRL, 1, 32'h60);
		chk(32'(auto_cal), 32'h1, "auto cal flag");
		sr_pulse(1, 6, 8, "auto cal tap");
		wr(ADDR_CAPTURE_CTRL, 1, 32'h40);
		sr_pulse(0, 0, 0, "rx off");
		$display("test capture done");
	endtask

	task automatic t_format();
		wr(ADDR_CAPTURE_CTRL, 1, 32'h61);
		wr(ADDR_CLK_FORMAT, 1, 32'(RST_CLK_FORMAT | 8'h01));
		chk(32'(flip), 32'h1, "flip on");
		sr_pulse(2, 5, 7, "flipped edge");
		wr(ADDR_CLK_FORMAT, 1, 32'(RST_CLK_FORMAT | 8'h06));
		chk(32'({dc_pecl, sr_pecl, flip}), 32'h6, "pecl bits");
		wr(ADDR_CLK_FORMAT, 1, 32'(RST_CLK_FORMAT | 8'h04));
		chk(32'({dc_pecl, sr_pecl, flip}), 32'h4, "device_clock_in pecl");
		rd(ADDR_CLK_FORMAT, 1, 32'(RST_CLK_FORMAT | 8'h04), "rmw");
		$display("test format done");
	endtask

	task automatic t_fs();
		wr(ADDR_FS_A_HI, 4, 32'h2000ffff);
		chk({fs_a, fs_b}, 32'h2000ffff, "fs stream");
		rd(ADDR_FS_A_HI, 4, 32'h2000ffff, "fs read");
		wr(ADDR_FS_A_LO, 1, 32'h5a);
		chk({fs_a, fs_b}, 32'h205affff, "fs independent");
		$display("test fullscale done");
	endtask

	task automatic t_misc();
		wr(ADDR_REF_BYPASS, 1, 32'h1);
		chk(32'(bypass), 32'h1, "bypass");
		wr(ADDR_TIMESTAMP, 1, 32'h3);
		chk(32'({ts_pecl, ts_on}), 32'h3, "ts on pecl");
		wr(ADDR_TIMESTAMP, 1, 32'h2);
		chk(32'({ts_pecl, ts_on}), 32'h2, "ts off");
		$display("test misc done");
	endtask

	task automatic report_and_stop();
		$display("counts: %0d mismatches, %0d comparisons", n_mismatch, n_tests);
		if (n_mismatch == 0 && n_tests > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	initial begin
		tick(10);
		rst_i = 1'b0;
		tick(5);
		t_reset();
		t_capture();
		t_format();
		t_fs();
		t_misc();
		report_and_stop();
	end

	// some 12k cycles expected; this leaves ample margin
	initial begin
		#800000;
		n_mismatch++;
		report_and_stop();
	end
endmodule
